// ---- rtl/alarm_manager.sv ----
/*
 * Loading arm alarm manager: alarm state per alarm, operations on
 * single alarms and on all alarms, per-arm severity, unacknowledged
 * counts, and an indication and a shutdown output for every arm.
 * Assumes raise and clear conditions arrive synchronous to CLK_IN,
 * one bit per alarm, and software on a classic Wishbone bus.
 */
// Contract
// - Two separate outputs per arm
// - Shutdown on when severity is pause or shutdown
// - Shutdown off when severity none or display
// - Indication on when unacked count leaves zero
// - Indication off when unacked count reaches zero
// - Raise each cycle activates only inactive alarm
// - Clear deactivates; holding condition reactivates at once
// - Auto-clear alarms obey their own clear condition
// - Reset normally acts as a clear
// - Retained state re-raises unless reset clears it
// - Acknowledge changes only asserted to acknowledged
// - Reset-all resets every active alarm
// - Acknowledge-all acknowledges every asserted alarm
// - Service reminder switch-off disables until reconfigured
// - Reset-all gives service reminder ordinary reset
// - State-changing ack or reset makes log record
// - Hardware reset input resets that arm's alarms
// - Device re-enable key clears every alarm
// - Arm severity is highest active affecting level
// - Level captured at activation only
// - Disabled alarms are ignored entirely; code only blocks raising, an active one stays counted
// - Unassociated stream alarms affect no arm
`timescale 1ns/10ps

module alarm_manager (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [alarm_pkg::ADR_W-1:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    input wire logic [alarm_pkg::NUM_ALARMS-1:0] RAISE_COND_IN,
    input wire logic [alarm_pkg::NUM_ALARMS-1:0] CLEAR_COND_IN,
    input wire logic [alarm_pkg::NUM_ARMS-1:0] ARM_RESET_IN,
    input wire logic DEVICE_REENABLE_IN,
    output logic [alarm_pkg::NUM_ARMS-1:0] ARM_IND_OUT,
    output logic [alarm_pkg::NUM_ARMS-1:0] ARM_SHUT_OUT,
    output logic [alarm_pkg::NUM_ALARMS-1:0] LOG_STROBE_OUT,
    output logic [alarm_pkg::NUM_ALARMS-1:0] ALARM_ACTIVE_OUT,
    output logic [alarm_pkg::NUM_ALARMS-1:0] ALARM_ACKED_OUT
);
    import alarm_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [NUM_ALARMS-1:0] active;
        logic [NUM_ALARMS-1:0] acked;
        logic [NUM_ALARMS-1:0] held;
        logic [NUM_ALARMS-1:0] off;
        logic [NUM_ALARMS-1:0] strobe;
        logic [NUM_ALARMS-1:0][1:0] level;
        logic [NUM_ALARMS-1:0][15:0] cfg;
        logic [NUM_ARMS-1:0] hw_en;
        logic [NUM_ARMS-1:0] hw_prev;
        logic reen_prev;
        logic [NUM_ARMS-1:0][CNT_W-1:0] cnt;
        logic [NUM_ARMS-1:0][1:0] sev;
        logic [NUM_ARMS-1:0] ind;
        logic [NUM_ARMS-1:0] shut;
        logic [15:0] log_cnt;
    } state_type;

    state_type s_q;
    state_type s_d;

    // ==========================================================
    // Arms affected by each alarm
    logic [NUM_ALARMS-1:0][NUM_ARMS-1:0] affect;

    genvar g;
    generate
        for (g = 0; g < NUM_ALARMS; g++) begin : g_affect
            logic [2:0] scope;
            logic [NUM_ARMS-1:0] one_arm;
            assign scope = s_q.cfg[g][CFG_SCOPE_LSB +: 3];
            assign one_arm = NUM_ARMS'(1) << s_q.cfg[g][CFG_ARM_LSB +: 2];
            always_comb begin
                affect[g] = '0;
                if (scope == SCOPE_DEVICE || scope == SCOPE_BAY) begin
                    affect[g] = '1;
                end else if (scope == SCOPE_ARM) begin
                    affect[g] = one_arm;
                end else if (scope == SCOPE_PRODUCT || scope == SCOPE_ADDITIVE) begin
                    // Stream alarms reach an arm only through association
                    affect[g] = s_q.cfg[g][CFG_ASSOC_BIT] ? one_arm : '0;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Next state
    always_comb begin
        logic req;
        logic wr;
        op_type op;
        logic [IDX_W-1:0] idx;
        logic [NUM_ARMS-1:0] hw_hit;
        logic reen_hit;
        logic [1:0] eff_act;
        logic sel_me;
        logic do_ack;
        logic do_clear;
        logic do_reset;
        logic do_off;
        logic raise;
        logic logged;
        logic [IDX_W-1:0] cfg_idx;
        logic [31:0] rd;
        req = 1'b0;
        wr = 1'b0;
        op = OP_NONE;
        idx = '0;
        hw_hit = '0;
        reen_hit = 1'b0;
        eff_act = ACT_DISABLED;
        sel_me = 1'b0;
        do_ack = 1'b0;
        do_clear = 1'b0;
        do_reset = 1'b0;
        do_off = 1'b0;
        raise = 1'b0;
        logged = 1'b0;
        cfg_idx = WB_ADR_IN[5:2];
        rd = '0;
        s_d = s_q;

        // Bus: one wait state, ack lasts one cycle
        req = WB_CYC_IN && WB_STB_IN;
        s_d.ack = req && !s_q.ack;
        wr = req && s_q.ack && WB_WE_IN;

        if (wr && WB_ADR_IN == OFF_CMD && WB_SEL_IN[0]) begin
            op = op_type'(WB_DAT_IN[CMD_OP_LSB +: 3]);
        end
        if (wr && WB_ADR_IN == OFF_CMD && WB_SEL_IN[1]) begin
            idx = WB_DAT_IN[CMD_IDX_LSB +: IDX_W];
        end
        if (wr && WB_ADR_IN == OFF_HWRST_EN && WB_SEL_IN[0]) begin
            s_d.hw_en = WB_DAT_IN[NUM_ARMS-1:0];
        end
        if (wr && WB_ADR_IN[7:6] == CFG_PAGE) begin
            if (WB_SEL_IN[0]) begin
                s_d.cfg[cfg_idx][7:0] = WB_DAT_IN[7:0];
            end
            if (WB_SEL_IN[1]) begin
                s_d.cfg[cfg_idx][15:8] = WB_DAT_IN[15:8];
            end
            // Reconfiguring brings back the configured action
            if (WB_SEL_IN[1:0] != 2'h0) begin
                s_d.off[cfg_idx] = 1'b0;
            end
        end

        // Hardware inputs act on their rising edge
        s_d.hw_prev = ARM_RESET_IN;
        s_d.reen_prev = DEVICE_REENABLE_IN;
        hw_hit = ARM_RESET_IN & ~s_q.hw_prev & s_q.hw_en;
        reen_hit = DEVICE_REENABLE_IN && !s_q.reen_prev;

        // Per alarm: operations first, then the periodic raise
        s_d.strobe = '0;
        for (int i = 0; i < NUM_ALARMS; i++) begin
            sel_me = (idx == IDX_W'(i));
            do_ack = ((op == OP_ACK) && sel_me) || (op == OP_ACK_ALL);
            do_clear = ((op == OP_CLEAR) && sel_me) || reen_hit;
            if (s_q.cfg[i][CFG_AUTO_BIT] && CLEAR_COND_IN[i]) begin
                do_clear = 1'b1;
            end
            do_reset = (op == OP_RESET_ALL) && s_q.active[i];
            if (|(hw_hit & affect[i])) begin
                do_reset = 1'b1;
            end
            do_off = 1'b0;
            if ((op == OP_RESET) && sel_me) begin
                if (i == SVC_ALARM) begin
                    do_off = 1'b1;
                end else begin
                    do_reset = 1'b1;
                end
            end
            logged = 1'b0;

            if (do_ack && s_q.active[i] && !s_q.acked[i]) begin
                s_d.acked[i] = 1'b1;
                logged = 1'b1;
            end
            if (do_clear) begin
                s_d.active[i] = 1'b0;
                s_d.acked[i] = 1'b0;
            end
            if (do_reset || do_off) begin
                // Ordinary reset is a clear
                s_d.active[i] = 1'b0;
                s_d.acked[i] = 1'b0;
                logged = logged || s_q.active[i];
                if (s_q.cfg[i][CFG_RSTCLR_BIT]) begin
                    s_d.held[i] = 1'b0;
                end
            end
            if (do_off) begin
                s_d.off[i] = 1'b1;
            end

            // Retained state is set after a reset: set wins
            if (s_q.cfg[i][CFG_RETAIN_BIT] && RAISE_COND_IN[i]) begin
                s_d.held[i] = 1'b1;
            end
            eff_act = s_d.off[i] ? ACT_DISABLED : s_q.cfg[i][CFG_ACT_LSB +: 2];
            raise = RAISE_COND_IN[i] || (s_q.cfg[i][CFG_RETAIN_BIT] && s_d.held[i]);
            if (raise && !s_d.active[i] && eff_act != ACT_DISABLED) begin
                s_d.active[i] = 1'b1;
                s_d.acked[i] = 1'b0;
                s_d.level[i] = eff_act;
            end
            s_d.strobe[i] = logged;
            if (logged) begin
                s_d.log_cnt = s_d.log_cnt + 16'h0001;
            end
        end

        // Per arm: count, severity and outputs from the new state
        for (int a = 0; a < NUM_ARMS; a++) begin
            s_d.cnt[a] = '0;
            s_d.sev[a] = ACT_DISABLED;
            for (int i = 0; i < NUM_ALARMS; i++) begin
                if (s_d.active[i] && affect[i][a]) begin
                    if (!s_d.acked[i]) begin
                        s_d.cnt[a] = s_d.cnt[a] + CNT_W'(1);
                    end
                    if (s_d.level[i] > s_d.sev[a]) begin
                        s_d.sev[a] = s_d.level[i];
                    end
                end
            end
            s_d.ind[a] = (s_d.cnt[a] != '0);
            s_d.shut[a] = (s_d.sev[a] >= ACT_PAUSE);
        end

        // Read data is latched with ack
        if (WB_ADR_IN[7:6] == CFG_PAGE) begin
            rd = {16'h0000, s_q.cfg[cfg_idx]};
        end else begin
            unique case (WB_ADR_IN)
                OFF_ACTIVE: rd = {16'h0000, s_q.active};
                OFF_ACKED: rd = {s_q.off, s_q.acked};
                OFF_ARM_OUT: rd = {16'h0000, s_q.sev, s_q.shut, s_q.ind};
                OFF_ARM_CNT: begin
                    for (int a = 0; a < NUM_ARMS; a++) begin
                        rd[a*8 +: 8] = {3'h0, s_q.cnt[a]};
                    end
                end
                OFF_HWRST_EN: rd = {28'h0000000, s_q.hw_en};
                OFF_LOG_CNT: rd = {16'h0000, s_q.log_cnt};
                default: rd = '0;
            endcase
        end
        s_d.rdata = s_d.ack ? rd : 32'h00000000;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    assign WB_ACK_OUT = s_q.ack;
    assign WB_DAT_OUT = s_q.rdata;
    assign ARM_IND_OUT = s_q.ind;
    assign ARM_SHUT_OUT = s_q.shut;
    assign LOG_STROBE_OUT = s_q.strobe;
    assign ALARM_ACTIVE_OUT = s_q.active;
    assign ALARM_ACKED_OUT = s_q.acked;

endmodule : alarm_manager

// ---- rtl/alarm_pkg.sv ----
/*
 * Constants for the loading arm alarm manager: sizes, register map,
 * configuration field layout, action levels, scope codes and commands.
 * Assumes a classic Wishbone slave port with 32-bit data and byte addresses.
 */
package alarm_pkg;

    // ==========================================================
    // Sizes
    localparam int NUM_ALARMS = 16;
    localparam int NUM_ARMS = 4;
    localparam int IDX_W = 4;
    localparam int CNT_W = 5;
    localparam int ADR_W = 8;
    localparam int SVC_ALARM = 0;

    // ==========================================================
    // Register byte offsets
    localparam logic [ADR_W-1:0] OFF_CMD = 8'h00;
    localparam logic [ADR_W-1:0] OFF_ACTIVE = 8'h04;
    localparam logic [ADR_W-1:0] OFF_ACKED = 8'h08;
    localparam logic [ADR_W-1:0] OFF_ARM_OUT = 8'h0C;
    localparam logic [ADR_W-1:0] OFF_ARM_CNT = 8'h10;
    localparam logic [ADR_W-1:0] OFF_HWRST_EN = 8'h14;
    localparam logic [ADR_W-1:0] OFF_LOG_CNT = 8'h18;
    localparam logic [1:0] CFG_PAGE = 2'h1;

    // ==========================================================
    // Command register fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_IDX_LSB = 8;

    // ==========================================================
    // Alarm configuration fields
    localparam int CFG_ACT_LSB = 0;
    localparam int CFG_SCOPE_LSB = 2;
    localparam int CFG_ARM_LSB = 5;
    localparam int CFG_ASSOC_BIT = 7;
    localparam int CFG_AUTO_BIT = 8;
    localparam int CFG_RETAIN_BIT = 9;
    localparam int CFG_RSTCLR_BIT = 10;

    // ==========================================================
    // Action levels, ordered so that a larger code is more severe
    localparam logic [1:0] ACT_DISABLED = 2'h0;
    localparam logic [1:0] ACT_DISPLAY = 2'h1;
    localparam logic [1:0] ACT_PAUSE = 2'h2;
    localparam logic [1:0] ACT_SHUTDOWN = 2'h3;

    // ==========================================================
    // Scope types
    localparam logic [2:0] SCOPE_DEVICE = 3'h0;
    localparam logic [2:0] SCOPE_BAY = 3'h1;
    localparam logic [2:0] SCOPE_ARM = 3'h2;
    localparam logic [2:0] SCOPE_PRODUCT = 3'h3;
    localparam logic [2:0] SCOPE_ADDITIVE = 3'h4;

    // ==========================================================
    // Software operations
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_CLEAR = 3'h1,
        OP_RESET = 3'h2,
        OP_ACK = 3'h3,
        OP_RESET_ALL = 3'h4,
        OP_ACK_ALL = 3'h5,
        OP_SPARE6 = 3'h6,
        OP_SPARE7 = 3'h7
    } op_type;

endpackage : alarm_pkg

// ---- dv/alarm_manager_sva.sv ----
/*
 * Port checker for alarm_manager, bound to every instance.
 * Assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/10ps
module alarm_manager_sva (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic [31:0] WB_DAT_OUT,
    input wire logic WB_ACK_OUT,
    input wire logic [alarm_pkg::NUM_ALARMS-1:0] RAISE_COND_IN,
    input wire logic DEVICE_REENABLE_IN,
    input wire logic [alarm_pkg::NUM_ARMS-1:0] ARM_IND_OUT,
    input wire logic [alarm_pkg::NUM_ARMS-1:0] ARM_SHUT_OUT,
    input wire logic [alarm_pkg::NUM_ALARMS-1:0] LOG_STROBE_OUT,
    input wire logic [alarm_pkg::NUM_ALARMS-1:0] ALARM_ACTIVE_OUT,
    input wire logic [alarm_pkg::NUM_ALARMS-1:0] ALARM_ACKED_OUT
);
    import alarm_pkg::*;
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    // ========
    // Bus
    bus_answer_a: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
        else $error("bus request not answered");
    ack_pulse_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
        else $error("bus ack longer than one cycle");
    ack_cause_a: assert property (WB_ACK_OUT |-> $past(WB_CYC_IN && WB_STB_IN))
        else $error("bus ack without request");
    rdata_idle_a: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == 32'h0)
        else $error("read data not zero outside ack");
    // ========
    // Alarm state and outputs
    acked_active_a: assert property ((ALARM_ACKED_OUT & ~ALARM_ACTIVE_OUT) == '0)
        else $error("acknowledged alarm not active");
    ind_unacked_a: assert property (ARM_IND_OUT != '0 |-> (ALARM_ACTIVE_OUT & ~ALARM_ACKED_OUT) != '0)
        else $error("indication without unacknowledged alarm");
    shut_active_a: assert property (ARM_SHUT_OUT != '0 |-> ALARM_ACTIVE_OUT != '0)
        else $error("shutdown without active alarm");
    log_change_a: assert property (
        (LOG_STROBE_OUT & ~((ALARM_ACTIVE_OUT ^ $past(ALARM_ACTIVE_OUT))
        | (ALARM_ACKED_OUT ^ $past(ALARM_ACKED_OUT)))) == '0)
        else $error("log strobe without state change");
    reenable_clear_a: assert property (
        $rose(DEVICE_REENABLE_IN) && RAISE_COND_IN == '0
        ##1 RAISE_COND_IN == '0 |=> ALARM_ACTIVE_OUT == '0)
        else $error("re-enable left an alarm active");
    cover property ($rose(ARM_IND_OUT[0]));
    cover property ($rose(|ARM_SHUT_OUT));
    cover property (|LOG_STROBE_OUT);
endmodule : alarm_manager_sva

bind alarm_manager alarm_manager_sva alarm_manager_sva_inst (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
    .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_DAT_OUT(WB_DAT_OUT),
    .WB_ACK_OUT(WB_ACK_OUT), .RAISE_COND_IN(RAISE_COND_IN),
    .DEVICE_REENABLE_IN(DEVICE_REENABLE_IN), .ARM_IND_OUT(ARM_IND_OUT),
    .ARM_SHUT_OUT(ARM_SHUT_OUT), .LOG_STROBE_OUT(LOG_STROBE_OUT),
    .ALARM_ACTIVE_OUT(ALARM_ACTIVE_OUT), .ALARM_ACKED_OUT(ALARM_ACKED_OUT));

// ---- dv/plant_io_model.sv ----
/*
 * Plant I/O and operator key model: turns bench requests into
 * registered condition levels, hardware reset and re-enable edges.
 * Assumes requests change just after a rising clock edge.
 */
`timescale 1ns/10ps
module plant_io_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [15:0] raise_in,
    input wire logic [15:0] clear_in,
    input wire logic [3:0] arm_rst_in,
    input wire logic reen_in,
    output logic [15:0] raise_out,
    output logic [15:0] clear_out,
    output logic [3:0] arm_rst_out,
    output logic reen_out
);
    typedef struct packed {
        logic [15:0] rs;
        logic [15:0] cl;
        logic [3:0] hw;
        logic rn;
    } io_type;
    io_type st_q;
    io_type st_d;
    always_comb begin
        st_d = {raise_in, clear_in, arm_rst_in, reen_in};
    end
    always_ff @(posedge clk_in) begin
        st_q <= rst_in ? '0 : st_d;
    end
    assign raise_out = st_q.rs;
    assign clear_out = st_q.cl;
    assign arm_rst_out = st_q.hw;
    assign reen_out = st_q.rn;
endmodule : plant_io_model

// ---- dv/testbench.sv ----
/*
 * Self-checking bench for alarm_manager with a behavioural alarm model.
 * Assumes the plant model delays every request by one clock.
 */
`timescale 1ns/10ps
module testbench;
    import alarm_pkg::*;
    logic clk, rst, cyc, stb, we, ack, nreq, reen;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, q;
    logic [15:0] rreq, creq, rc, cc, held, lf, apin, kpin, ls;
    logic [3:0] hreq, hw, ind, shut;
    int n_fail, tests_run, cyc_n, i, off0, lg, ls_n;
    int act[16], akd[16], lvl[16], cfg[16];
    int ctab[8] = '{0, 'h001, 'h006, 'h02B, 'h0CE, 'h073, 'h169, 'h008};
    alarm_manager alarm_manager_inst (.CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc),
        .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF),
        .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .RAISE_COND_IN(rc),
        .CLEAR_COND_IN(cc), .ARM_RESET_IN(hw), .DEVICE_REENABLE_IN(reen),
        .ARM_IND_OUT(ind), .ARM_SHUT_OUT(shut), .LOG_STROBE_OUT(ls),
        .ALARM_ACTIVE_OUT(apin), .ALARM_ACKED_OUT(kpin));
    plant_io_model plant_io_model_inst (.clk_in(clk), .rst_in(rst), .raise_in(rreq),
        .clear_in(creq), .arm_rst_in(hreq), .reen_in(nreq), .raise_out(rc),
        .clear_out(cc), .arm_rst_out(hw), .reen_out(reen));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ========
    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc_n++;
        ls_n <= ls_n + $countones(ls);
        if (cyc_n == 20000) begin
            n_fail++;
            end_sim();
        end
    end
    // ========
    // Shared tasks
    task automatic end_sim();
        if (n_fail == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    function automatic logic [15:0] nx(input logic [15:0] l);
        return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
    endfunction : nx
    function automatic bit aff(input int k, input int a);
        int sc;
        sc = (cfg[k] >> 2) & 7;
        if (sc < 2) return 1;
        if (((cfg[k] >> 5) & 3) != a) return 0;
        return sc == 2 || (sc < 5 && ((cfg[k] >> 7) & 1) == 1);
    endfunction : aff
    task automatic setcfg(input int k, input int v);
        cfg[k] = v;
        wb(1'b1, 8'(64 + 4 * k), 32'(v));
    endtask : setcfg
    task automatic op(input int o, input int k);
        wb(1'b1, OFF_CMD, 32'(k * 256 + o));
        for (int j = 0; j < 16; j++) begin
            if (((o == 3 && j == k) || o == 5) && act[j] != 0 && akd[j] == 0) begin
                akd[j] = 1;
                lg++;
            end
            if (((o == 1 || o == 2) && j == k) || o == 4) begin
                if (o != 1 && act[j] != 0) lg++;
                act[j] = 0;
                akd[j] = 0;
            end
        end
    endtask : op
    // Raise after clear: a raise in the same cycle wins
    task automatic pulse(input logic [15:0] r, c, input logic [3:0] h, input logic n);
        @(posedge clk);
        rreq <= r | held;
        creq <= c;
        hreq <= h;
        nreq <= n;
        @(posedge clk);
        rreq <= held;
        creq <= '0;
        hreq <= '0;
        nreq <= 1'b0;
        repeat (4) @(posedge clk);
        for (int k = 0; k < 16; k++) begin
            for (int a = 0; a < 4; a++) if (h[a] && aff(k, a) && act[k] != 0) begin
                act[k] = 0;
                lg++;
            end
            if (n || (c[k] && cfg[k][8]) || act[k] == 0) akd[k] = 0;
            if (n || (c[k] && cfg[k][8])) act[k] = 0;
            if (r[k] && act[k] == 0 && (cfg[k] & 3) != 0) begin
                act[k] = 1;
                lvl[k] = cfg[k] & 3;
            end
        end
    endtask : pulse
    task automatic compare();
        int c, s;
        logic [31:0] ea, ek, eo, ec;
        ea = 0;
        ek = 32'(off0) << 16;
        eo = 0;
        ec = 0;
        for (int k = 0; k < 16; k++) begin
            ea[k] = act[k] != 0;
            ek[k] = akd[k] != 0;
        end
        for (int a = 0; a < 4; a++) begin
            c = 0;
            s = 0;
            for (int k = 0; k < 16; k++) if (act[k] != 0 && aff(k, a)) begin
                c += (akd[k] == 0);
                s = lvl[k] > s ? lvl[k] : s;
            end
            eo[a] = c > 0;
            eo[4 + a] = s >= 2;
            eo[8 + 2 * a +: 2] = s[1:0];
            ec[8 * a +: 8] = c[7:0];
        end
        wb(1'b0, OFF_ACTIVE, 0);
        chk("active", q, ea);
        wb(1'b0, OFF_ACKED, 0);
        chk("acked", q, ek);
        wb(1'b0, OFF_ARM_OUT, 0);
        chk("arm_out", q, eo);
        chk("ind_pin", ind, eo[3:0]);
        chk("shut_pin", shut, eo[7:4]);
        wb(1'b0, OFF_ARM_CNT, 0);
        chk("count", q, ec);
        chk("active_pin", apin, ea);
        chk("acked_pin", kpin, ek[15:0]);
        wb(1'b0, OFF_LOG_CNT, 0);
        chk("log_cnt", q, 32'(lg));
        chk("log_strobes", 32'(ls_n), 32'(lg));
    endtask : compare
    // ========
    // Main sequence
    initial begin
        {rst, cyc, stb, we, nreq} = 5'h10;
        {adr, wdat, rreq, creq, hreq, held} = '0;
        lf = 16'h005A;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        compare();
        wb(1'b0, 8'h30, 0);
        chk("unmapped", q, 0);
        wb(1'b1, OFF_HWRST_EN, 32'hF);
        wb(1'b0, OFF_HWRST_EN, 0);
        chk("hw_en", q, 32'hF);
        for (int k = 1; k < 8; k++) setcfg(k, ctab[k]);
        repeat (60) begin
            lf = nx(lf);
            pulse(lf & 16'h00FE, 0, 0, 0);
            lf = nx(lf);
            i = int'(lf[15:13]) % 7 + 1;
            case (lf[2:0])
                0: op(3, i);
                1: op(2, i);
                2: op(1, i);
                3: op(4, i);
                4: op(5, i);
                5: setcfg(i, (ctab[i] & ~3) | int'(lf[9:8]));
                6: pulse(0, lf & 16'h00FE, 0, 0);
                default: pulse(0, 0, lf[10] ? 4'(1 << lf[12:11]) : 4'h0, !lf[10]);
            endcase
            compare();
        end
        pulse(0, 0, 0, 1);
        held = 16'h0001;
        pulse(0, 0, 0, 0);
        setcfg(0, 'h009);
        act[0] = 1;
        lvl[0] = 1;
        op(3, 0);
        compare();
        op(4, 0);
        act[0] = 1;
        compare();
        op(2, 0);
        off0 = 1;
        compare();
        setcfg(0, 'h009);
        {off0, act[0]} = {32'd0, 32'd1};
        compare();
        // Retained alarm: reset re-raises until the reset also drops the state
        setcfg(7, 'h209);
        pulse(16'h0080, 0, 0, 0);
        op(3, 7);
        op(2, 7);
        act[7] = 1;
        compare();
        setcfg(7, 'h609);
        op(2, 7);
        compare();
        end_sim();
    end
endmodule : testbench
